// [hims_host_model.sv]
/*
  Host microcontroller model: resolves the open-drain interrupt wire and
  services it by level. Assumes the pull-up sits outside the device.
*/
`timescale 1ns/1ns
module hims_host_model #(
  parameter int EVENT_W = 8
) (
  input  wire logic               clk_in,
  input  wire logic               service_en_in,
  input  wire logic               int_n_in,
  input  wire logic               int_oe_n_in,
  input  wire logic [EVENT_W-1:0] status_in,
  output logic [EVENT_W-1:0]      status_clear_out = '0
);
  // pull-up wins while the device lets go of the wire
  wire irq_wire_n = int_oe_n_in ? 1'h1 : int_n_in;
  // level sensitive: keeps clearing while the wire stays low, so no event is lost
  always_ff @(posedge clk_in) status_clear_out <= (service_en_in && !irq_wire_n) ? status_in : '0;
endmodule

// [hims_monitor.sv]
/*
  Checker of hims_top: pin decode, serial output edge and interrupt timing.
  Assumes one clock and the synchronous reset of the top; bound below.
*/
`timescale 1ns/1ns
module hims_monitor #(
  parameter int EVENT_W = 8
) (
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic [1:0]           mode_level_in,
  input wire logic                 bus_style_select_in,
  input wire logic                 rw_select_in,
  input wire logic                 data_strobe_n_in,
  input wire logic                 shift_clk_in,
  input wire logic                 edge_select_in,
  input wire logic                 serial_bit_in,
  input wire logic [EVENT_W-1:0]   event_in,
  input wire logic [EVENT_W-1:0]   irq_enable_in,
  input wire hims_pkg::hims_mode_e mode_out,
  input wire hims_pkg::hims_bus_e  bus_out,
  input wire hims_pkg::hims_host_s host_out,
  input wire hims_pkg::hims_hw_s   hw_out,
  input wire logic                 serial_out,
  input wire logic [EVENT_W-1:0]   status_out,
  input wire logic                 int_n_out,
  input wire logic                 int_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // decoded views of the registered mode and bus style
  wire hw_m  = mode_out == hims_pkg::HIMS_MODE_HARDWARE;
  wire ser_m = mode_out == hims_pkg::HIMS_MODE_SERIAL;
  wire par_m = mode_out == hims_pkg::HIMS_MODE_PARALLEL;
  wire sep_b = bus_out == hims_pkg::HIMS_BUS_SEPARATE;
  // four equal samples: both pipeline stages have caught up with the pins
  sequence s_settled;
    $stable({mode_level_in, bus_style_select_in, rw_select_in, data_strobe_n_in})[*3];
  endsequence
  sequence s_event;
    |(event_in & irq_enable_in) ##1 $stable(irq_enable_in);
  endsequence
  property p_mode; s_settled |-> {par_m, ser_m} == {&mode_level_in, mode_level_in == 2'h1}; endproperty
  property p_bus; s_settled |-> sep_b == bus_style_select_in; endproperty
  property p_hw; s_settled ##0 hw_m |-> !host_out.parallel_en &&
    hw_out == {rw_select_in, data_strobe_n_in, !bus_style_select_in, 1'h1}; endproperty
  property p_host; s_settled ##0 par_m |-> host_out.parallel_en && (sep_b ?
    {host_out.host_read, host_out.host_write} == ~{rw_select_in, data_strobe_n_in} :
    host_out.host_strobe != data_strobe_n_in); endproperty
  property p_ser; s_settled ##0 ser_m |-> host_out.serial_en && !host_out.parallel_en &&
    host_out.serial_in == data_strobe_n_in; endproperty
  property p_sout; ser_m && (edge_select_in ? $fell(shift_clk_in) : $rose(shift_clk_in))
    |=> serial_out == $past(serial_bit_in); endproperty
  property p_irq; s_event |=> !int_oe_n_out && !int_n_out; endproperty
  property p_hold; !int_oe_n_out && |(status_out & irq_enable_in) |=> !int_oe_n_out; endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  a_bus: assert property (p_bus) else $error("bus style");
  a_hw: assert property (p_hw) else $error("hardware pins");
  a_host: assert property (p_host) else $error("parallel roles");
  a_ser: assert property (p_ser) else $error("serial roles");
  a_sout: assert property (p_sout) else $error("serial edge");
  a_irq: assert property (p_irq) else $error("interrupt late");
  a_hold: assert property (p_hold) else $error("interrupt dropped");
endmodule
bind hims_top hims_monitor #(.EVENT_W(EVENT_W)) hims_monitor_inst (.*);

// [hims_pin_mux.sv]
/*
  Pin role decoder: turns the decoded mode, bus style and the raw shared pins into
  host-side roles and hardware-mode settings. Purely combinational.
  Assumes all pins are synchronous to the clock of the instantiating module.
*/
`timescale 1ns/1ns
module hims_pin_mux (
  input  wire hims_pkg::hims_mode_e mode_in,
  input  wire hims_pkg::hims_bus_e  bus_in,
  input  wire logic                 bus_style_select_in,
  input  wire logic                 rw_select_in,
  input  wire logic                 data_strobe_n_in,
  output hims_pkg::hims_host_s      host_out,
  output hims_pkg::hims_hw_s        hw_out
);

  wire is_hw       = (mode_in == hims_pkg::HIMS_MODE_HARDWARE);
  wire is_par      = (mode_in == hims_pkg::HIMS_MODE_PARALLEL);
  wire is_ser      = (mode_in == hims_pkg::HIMS_MODE_SERIAL);
  wire is_strobe   = (bus_in == hims_pkg::HIMS_BUS_STROBE);
  wire strobe_act  = (data_strobe_n_in == hims_pkg::HIMS_PIN_LOW);

  // strobe style: rw is direction, strobe is data strobe; separate style: low enables
  assign host_out.host_strobe    = is_par & is_strobe & strobe_act;
  assign host_out.host_dir_write = is_par & is_strobe & ~rw_select_in;
  assign host_out.host_read      = is_par & (is_strobe ? (strobe_act & rw_select_in)
                                                       : ~rw_select_in);
  assign host_out.host_write     = is_par & (is_strobe ? (strobe_act & ~rw_select_in)
                                                       : strobe_act);
  // serial mode: the strobe pin is the serial data input, parallel port idle
  assign host_out.serial_in      = is_ser & data_strobe_n_in;
  assign host_out.parallel_en    = is_par;
  assign host_out.serial_en      = is_ser;

  // hardware mode: shared pins become static line length and line code settings
  assign hw_out.line_length      = is_hw ? {rw_select_in, data_strobe_n_in}
                                         : {hims_pkg::HIMS_LEN_W{1'b0}};
  assign hw_out.line_code_enable = is_hw & (bus_style_select_in == hims_pkg::HIMS_PIN_LOW);
  assign hw_out.hw_en            = is_hw;

endmodule

// [hims_pkg.sv]
/*
  Package for the host interface mode select block: operating modes, bus styles,
  level constants and the packed structs that carry the decoded pin roles.
  Assumes nothing of its surroundings; used by hims_pin_mux and hims_top.
*/
package hims_pkg;

  // operating mode chosen by the three-level mode pin
  typedef enum logic [1:0] {
    HIMS_MODE_HARDWARE,
    HIMS_MODE_PARALLEL,
    HIMS_MODE_SERIAL
  } hims_mode_e;

  // parallel bus style chosen by the bus-style pin
  typedef enum logic {
    HIMS_BUS_STROBE,
    HIMS_BUS_SEPARATE
  } hims_bus_e;

  // the mode pin arrives as two comparator outputs: above the low band, above the mid band
  localparam logic [1:0] HIMS_LVL_LOW  = 2'h0;
  localparam logic [1:0] HIMS_LVL_MID  = 2'h1;
  localparam logic [1:0] HIMS_LVL_HIGH = 2'h3;

  localparam logic HIMS_PIN_LOW  = 1'h0;
  localparam logic HIMS_PIN_HIGH = 1'h1;

  localparam int HIMS_LEN_W   = 2;
  localparam int HIMS_EVENT_W = 8;

  // roles taken by the shared host pins in host modes
  typedef struct packed {
    logic host_read;
    logic host_write;
    logic host_strobe;
    logic host_dir_write;
    logic serial_in;
    logic parallel_en;
    logic serial_en;
  } hims_host_s;

  // static settings taken by the shared pins in hardware mode
  typedef struct packed {
    logic [HIMS_LEN_W-1:0] line_length;
    logic                  line_code_enable;
    logic                  hw_en;
  } hims_hw_s;

endpackage

// [hims_top.sv]
/*
  Host interface mode select top: decodes the three-level mode pin and bus style,
  routes the shared pins, aligns the serial output edge and drives the open-drain
  interrupt. Assumes pins synchronous to clk_in and an external pull-up on the
  interrupt wire; the serial shift clock arrives as a sampled ordinary input.
*/
`timescale 1ns/1ns
module hims_top #(
  parameter int EVENT_W = hims_pkg::HIMS_EVENT_W
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic [1:0]         mode_level_in,
  input  wire logic               bus_style_select_in,
  input  wire logic               rw_select_in,
  input  wire logic               data_strobe_n_in,
  input  wire logic               shift_clk_in,
  input  wire logic               edge_select_in,
  input  wire logic               serial_bit_in,
  input  wire logic [EVENT_W-1:0] event_in,
  input  wire logic [EVENT_W-1:0] irq_enable_in,
  input  wire logic [EVENT_W-1:0] status_clear_in,
  output hims_pkg::hims_mode_e    mode_out,
  output hims_pkg::hims_bus_e     bus_out,
  output hims_pkg::hims_host_s    host_out,
  output hims_pkg::hims_hw_s      hw_out,
  output logic                    serial_out,
  output logic [EVENT_W-1:0]      status_out,
  output logic                    int_n_out,
  output logic                    int_oe_n_out
);

  hims_pkg::hims_mode_e mode_q;
  hims_pkg::hims_mode_e mode_d;
  hims_pkg::hims_bus_e  bus_q;
  hims_pkg::hims_bus_e  bus_d;
  hims_pkg::hims_host_s host_d;
  hims_pkg::hims_host_s host_q;
  hims_pkg::hims_hw_s   hw_d;
  hims_pkg::hims_hw_s   hw_q;
  logic                 sclk_q;
  logic                 serial_q;
  logic [EVENT_W-1:0]   status_q;
  logic                 int_q;

  // three-level decode; an illegal comparator pair falls back to hardware mode
  assign mode_d = (mode_level_in == hims_pkg::HIMS_LVL_HIGH) ? hims_pkg::HIMS_MODE_PARALLEL :
                  (mode_level_in == hims_pkg::HIMS_LVL_MID)  ? hims_pkg::HIMS_MODE_SERIAL :
                                                               hims_pkg::HIMS_MODE_HARDWARE;

  // bus style only meaningful in host modes; the pin is line code in hardware mode
  assign bus_d = (bus_style_select_in == hims_pkg::HIMS_PIN_HIGH) ? hims_pkg::HIMS_BUS_SEPARATE
                                                                  : hims_pkg::HIMS_BUS_STROBE;

  hims_pin_mux u_mux (
    .mode_in             (mode_q),
    .bus_in              (bus_q),
    .bus_style_select_in (bus_style_select_in),
    .rw_select_in        (rw_select_in),
    .data_strobe_n_in    (data_strobe_n_in),
    .host_out            (host_d),
    .hw_out              (hw_d)
  );

  // serial output edge: change on the edge opposite the one the host samples on
  wire sclk_rise  = shift_clk_in & ~sclk_q;
  wire sclk_fall  = ~shift_clk_in & sclk_q;
  wire ser_update = (edge_select_in == hims_pkg::HIMS_PIN_HIGH) ? sclk_fall : sclk_rise;
  wire ser_active = (mode_q == hims_pkg::HIMS_MODE_SERIAL);

  // sticky status: a new event beats a clear in the same cycle
  wire [EVENT_W-1:0] status_d = event_in | (status_q & ~status_clear_in);
  wire               int_d    = |(status_q & irq_enable_in);

  // mode and bus style registered so every shared pin changes role cleanly
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= hims_pkg::HIMS_MODE_HARDWARE;
      bus_q  <= hims_pkg::HIMS_BUS_STROBE;
      host_q <= '0;
      hw_q   <= '0;
    end else begin
      mode_q <= mode_d;
      bus_q  <= bus_d;
      host_q <= host_d;
      hw_q   <= hw_d;
    end
  end

  // serial bit launch; held low outside serial mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_q   <= 1'b0;
      serial_q <= 1'b0;
    end else begin
      sclk_q <= shift_clk_in;
      if (!ser_active) begin
        serial_q <= 1'b0;
      end else if (ser_update) begin
        serial_q <= serial_bit_in;
      end
    end
  end

  // interrupt is a level: it stays asserted while any enabled status remains
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_q <= '0;
      int_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      int_q    <= int_d;
    end
  end

  assign mode_out     = mode_q;
  assign bus_out      = bus_q;
  assign host_out     = host_q;
  assign hw_out       = hw_q;
  assign serial_out   = serial_q;
  assign status_out   = status_q;
  // open drain: only ever drives low, enable low while driving
  assign int_n_out    = 1'b0;
  assign int_oe_n_out = ~int_q;

endmodule

// [tb_top.sv]
/*
  Self-checking bench for hims_top with a level-servicing host model.
  Assumes package, design, checker and model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  logic                 clk_in = 1'h0, rst_in = 1'h1, bus_style_select_in = 1'h0;
  logic [1:0]           mode_level_in = 2'h0;
  logic                 rw_select_in = 1'h0, data_strobe_n_in = 1'h1, shift_clk_in = 1'h0;
  logic                 edge_select_in = 1'h0, serial_bit_in = 1'h0, service_en = 1'h0;
  logic [7:0]           event_in = 8'h00, irq_enable_in = 8'h00, status_clear_in, status_out;
  hims_pkg::hims_mode_e mode_out;
  hims_pkg::hims_bus_e  bus_out;
  hims_pkg::hims_host_s host_out;
  hims_pkg::hims_hw_s   hw_out;
  logic                 serial_out, int_n_out, int_oe_n_out;
  int                   miscompares = 0, cmp_count = 0;
  always #10 clk_in = ~clk_in;
  hims_top hims_top_inst (.*);
  hims_host_model hims_host_model_inst (.clk_in(clk_in), .service_en_in(service_en),
    .int_n_in(int_n_out), .int_oe_n_in(int_oe_n_out), .status_in(status_out),
    .status_clear_out(status_clear_in));
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // sample a little after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one pin setting: mode code, bus style, rw and strobe levels
  task automatic t_pins(input logic [4:0] v);
    @(posedge clk_in);
    {mode_level_in, bus_style_select_in, rw_select_in, data_strobe_n_in} <= v;
    tick(3);
    chk(mode_out === (v[4:3] == 2'h3 ? hims_pkg::HIMS_MODE_PARALLEL : v[4:3] == 2'h1 ?
      hims_pkg::HIMS_MODE_SERIAL : hims_pkg::HIMS_MODE_HARDWARE), "mode decode");
    chk(bus_out === (v[2] ? hims_pkg::HIMS_BUS_SEPARATE : hims_pkg::HIMS_BUS_STROBE),
      "bus style");
    chk(hw_out === ((v[4:3] == 2'h0 || v[4:3] == 2'h2) ? {v[1], v[0], ~v[2], 1'h1} : 4'h0),
      "hardware settings");
    chk(host_out === ((v[4:3] == 2'h3) ? (v[2] ? {~v[1], ~v[0], 5'h02} :
      {~v[0] & v[1], ~v[0] & ~v[1], ~v[0], ~v[1], 3'h2}) :
      (v[4:3] == 2'h1) ? {4'h0, v[0], 2'h1} : 7'h00), "host roles");
  endtask
  task automatic t_serial(input logic es);
    logic [7:0] pat;
    pat = 8'hA5 ^ {8{es}};
    @(posedge clk_in);
    mode_level_in <= 2'h1;
    edge_select_in <= es;
    shift_clk_in <= es;
    for (int k = 0; k < 8; k++) begin
      tick(2);
      serial_bit_in <= pat[k];
      shift_clk_in <= ~es;
      @(posedge clk_in);
      serial_bit_in <= ~pat[k];  // moves after the capture edge: a late capture shows
      shift_clk_in <= es;
      tick(1);
      chk(serial_out === pat[k], "serial bit");
    end
  endtask
  task automatic t_irq;
    int n;
    @(posedge clk_in);
    irq_enable_in <= 8'h01;
    event_in <= 8'h83;
    @(posedge clk_in);
    event_in <= 8'h00;
    tick(5);
    chk(int_oe_n_out === 1'h0 && status_out === 8'h83, "held interrupt");
    service_en <= 1'h1;
    for (n = 0; n < 10 && int_oe_n_out !== 1'h1; n++) tick(1);
    chk(n < 10 && status_out === 8'h00, "release after service");
    if (n == 10) summarize();
    event_in <= 8'h02;
    @(posedge clk_in);
    event_in <= 8'h00;
    tick(4);
    chk(int_oe_n_out === 1'h1 && status_out === 8'h02, "masked event");
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 32; i++) t_pins(i[4:0]);
    t_serial(1'h0);
    t_serial(1'h1);
    t_irq();
    summarize();
  end
endmodule
